// [core/dmmfd_consts.vh]
// Constants for the multimeter function decoder register port and encodings
`ifndef DMMFD_CONSTS_VH
`define DMMFD_CONSTS_VH

// Register addresses (word index on the plain port)
`define DMMFD_ADDR_FUNC      4'h0
`define DMMFD_ADDR_RANGE     4'h1
`define DMMFD_ADDR_CTRL      4'h2
`define DMMFD_ADDR_STATUS    4'h3

// Control register field positions
`define DMMFD_CTRL_OSS_LSB   0
`define DMMFD_CTRL_OSS_MSB   1
`define DMMFD_CTRL_DIV_BIT   2
`define DMMFD_CTRL_CLVL_BIT  3

// Reset values
`define DMMFD_FUNC_RST       4'h0
`define DMMFD_RANGE_RST      4'h0
`define DMMFD_OSS_RST        2'h0
`define DMMFD_DIV_RST        1'h0
`define DMMFD_CLVL_RST       1'h0
`define DMMFD_BIT_RST        1'h0
`define DMMFD_CODE3_RST      3'h0
`define DMMFD_CODE2_RST      2'h0
`define DMMFD_RDATA_RST      8'h00

// Ohm source select encodings
`define DMMFD_OSS_HIZ        2'h0
`define DMMFD_OSS_AUX5       2'h1
`define DMMFD_OSS_REFLVL     2'h2
`define DMMFD_OSS_SUPPLY     2'h3

// Ohm source output path codes
`define DMMFD_OSO_HIZ        3'h0
`define DMMFD_OSO_AUX5       3'h1
`define DMMFD_OSO_REFLVL     3'h2
`define DMMFD_OSO_SUPPLY     3'h3
`define DMMFD_OSO_GND        3'h4

`endif

// [core/dmmfd_top.v]
// Multimeter function decoder with register port and switch code outputs
//
// Summary of operation
// - Function code decodes to cap, diode, source, short and direct-out flags.
// - Range bits a,b,c,d drive 1k, 10k, 100k, 1M switch codes.
// - Divider mode 00xx: switch codes 0aa, 10M code 0e.
// - e is OR of range bits, f its complement, used in 10M code.
// - Codes 1000..1011: each resistor switch code is its bit tripled.
// - 10M code is f1 for 1000/1010 and ff for 1001/1011.
// - Reference generator outputs all zero unless source voltage enabled.
// - Divider select from register bit; source enable only from decode.
// - Divider select 0 picks zener reference, 1 picks supply rail.
// - cap_range_level picks between two comparator reference sets.
// - Without cap mode, ohm source follows ohm_source_select field.
// - In cap mode, toggle 0 gives reference level, 1 gives ground.
// - Charge/discharge toggle follows comparator one output.
`timescale 1ns/10ps

module dmmfd_top (
    // Clock and reset
    input  wire       sys_clk_i,
    input  wire       rst_i,
    // Register port
    input  wire [3:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    // Comparator pin
    input  wire       comparator_one_i,
    // Decoded flags
    output reg        cap_measure_flag_o,
    output reg        diode_test_flag_o,
    output reg        source_voltage_enable_o,
    output reg        short_test_flag_o,
    output reg        direct_voltage_out_enable_o,
    // Resistor network switch codes
    output reg  [2:0] sw_1k_ctrl_o,
    output reg  [2:0] sw_10k_ctrl_o,
    output reg  [2:0] sw_100k_ctrl_o,
    output reg  [2:0] sw_1meg_ctrl_o,
    output reg  [1:0] sw_10meg_ctrl_o,
    // Reference generator controls
    output reg        ref_gen_enable_o,
    output reg        ref_sel_zener_o,
    output reg        ref_sel_supply_o,
    output reg        cmp_ref_set1_o,
    output reg        cmp_ref_set2_o,
    output reg        cmp_ref_discharge_o,
    // Ohm source path and toggle
    output reg  [2:0] ohm_source_output_o,
    output reg        charge_discharge_toggle_o
);

`include "dmmfd_consts.vh"

    // Holding registers
    reg [3:0] func_q;
    reg [3:0] range_q;
    reg [1:0] oss_q;
    reg       div_sel_q;
    reg       cap_lvl_q;
    reg       cmp_meta_q;
    reg       cmp_sync_q;

    // Settings registers, cleared by reset
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            func_q    <= `DMMFD_FUNC_RST;
            range_q   <= `DMMFD_RANGE_RST;
            oss_q     <= `DMMFD_OSS_RST;
            div_sel_q <= `DMMFD_DIV_RST;
            cap_lvl_q <= `DMMFD_CLVL_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DMMFD_ADDR_FUNC: begin
                    func_q <= reg_wdata_i[3:0];
                end
                `DMMFD_ADDR_RANGE: begin
                    range_q <= reg_wdata_i[3:0];
                end
                `DMMFD_ADDR_CTRL: begin
                    oss_q     <= reg_wdata_i[`DMMFD_CTRL_OSS_MSB:`DMMFD_CTRL_OSS_LSB];
                    div_sel_q <= reg_wdata_i[`DMMFD_CTRL_DIV_BIT];
                    cap_lvl_q <= reg_wdata_i[`DMMFD_CTRL_CLVL_BIT];
                end
                default: begin
                    // Status and unmapped writes are dropped
                end
            endcase
        end
    end

    // Comparator pin synchroniser; only the second stage is read
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmp_meta_q <= `DMMFD_BIT_RST;
            cmp_sync_q <= `DMMFD_BIT_RST;
        end else begin
            cmp_meta_q <= comparator_one_i;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Function decode into the five mode flags
    reg       cap_d;
    reg       diode_d;
    reg       src_en_d;
    reg       short_d;
    reg       dir_out_d;
    always @* begin
        cap_d     = 1'h0;
        diode_d   = 1'h0;
        src_en_d  = 1'h0;
        short_d   = 1'h0;
        dir_out_d = 1'h0;
        case (func_q)
            4'h1: begin
                diode_d = 1'h1;
            end
            4'h3: begin
                src_en_d  = 1'h1;
                dir_out_d = 1'h1;
            end
            4'h8, 4'h9: begin
                src_en_d = 1'h1;
                short_d  = 1'h1;
            end
            4'hA, 4'hB: begin
                cap_d    = 1'h1;
                src_en_d = 1'h1;
            end
            default: begin
                // 0000, 0010, 01xx and 11xx leave every flag low
            end
        endcase
    end

    // Mode groups that pick the switch code form
    wire       div_mode_w = (func_q[3:2] == 2'h0);
    wire       rc_mode_w  = (func_q[3:2] == 2'h2);
    wire       e_w        = |range_q;
    wire       f_w        = ~e_w;

    // One switch lane per resistor path, range bits a to d
    wire [2:0] s1k_w;
    wire [2:0] s10k_w;
    wire [2:0] s100k_w;
    wire [2:0] s1m_w;

    dmmfd_sw_lane #(
        .WIDTH       (3)
    ) u_dmmfd_sw_lane_1k (
        .div_mode_i  (div_mode_w),
        .rc_mode_i   (rc_mode_w),
        .range_bit_i (range_q[3]),
        .code_o      (s1k_w)
    );

    dmmfd_sw_lane #(
        .WIDTH       (3)
    ) u_dmmfd_sw_lane_10k (
        .div_mode_i  (div_mode_w),
        .rc_mode_i   (rc_mode_w),
        .range_bit_i (range_q[2]),
        .code_o      (s10k_w)
    );

    dmmfd_sw_lane #(
        .WIDTH       (3)
    ) u_dmmfd_sw_lane_100k (
        .div_mode_i  (div_mode_w),
        .rc_mode_i   (rc_mode_w),
        .range_bit_i (range_q[1]),
        .code_o      (s100k_w)
    );

    dmmfd_sw_lane #(
        .WIDTH       (3)
    ) u_dmmfd_sw_lane_1meg (
        .div_mode_i  (div_mode_w),
        .rc_mode_i   (rc_mode_w),
        .range_bit_i (range_q[0]),
        .code_o      (s1m_w)
    );

    // 10M path code: 0e in divider mode, f1 or ff in R and C modes
    reg  [1:0] s10m_d;
    always @* begin
        s10m_d = 2'h0;
        if (div_mode_w) begin
            s10m_d = {1'h0, e_w};
        end else if (rc_mode_w) begin
            if (func_q[0]) begin
                s10m_d = {f_w, f_w};
            end else begin
                s10m_d = {f_w, 1'h1};
            end
        end
    end

    // Ohm source path selection; capacitor mode ignores the select field
    wire      tog_w = cmp_sync_q;
    reg [2:0] oso_d;
    always @* begin
        if (cap_d) begin
            oso_d = tog_w ? `DMMFD_OSO_GND : `DMMFD_OSO_REFLVL;
        end else begin
            case (oss_q)
                `DMMFD_OSS_HIZ:    oso_d = `DMMFD_OSO_HIZ;
                `DMMFD_OSS_AUX5:   oso_d = `DMMFD_OSO_AUX5;
                `DMMFD_OSS_REFLVL: oso_d = `DMMFD_OSO_REFLVL;
                default:           oso_d = `DMMFD_OSO_SUPPLY;
            endcase
        end
    end

    // Output registers; every pin-facing value comes from a flop
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            cap_measure_flag_o          <= `DMMFD_BIT_RST;
            diode_test_flag_o           <= `DMMFD_BIT_RST;
            source_voltage_enable_o     <= `DMMFD_BIT_RST;
            short_test_flag_o           <= `DMMFD_BIT_RST;
            direct_voltage_out_enable_o <= `DMMFD_BIT_RST;
            sw_1k_ctrl_o                <= `DMMFD_CODE3_RST;
            sw_10k_ctrl_o               <= `DMMFD_CODE3_RST;
            sw_100k_ctrl_o              <= `DMMFD_CODE3_RST;
            sw_1meg_ctrl_o              <= `DMMFD_CODE3_RST;
            sw_10meg_ctrl_o             <= `DMMFD_CODE2_RST;
            ref_gen_enable_o            <= `DMMFD_BIT_RST;
            ref_sel_zener_o             <= `DMMFD_BIT_RST;
            ref_sel_supply_o            <= `DMMFD_BIT_RST;
            cmp_ref_set1_o              <= `DMMFD_BIT_RST;
            cmp_ref_set2_o              <= `DMMFD_BIT_RST;
            cmp_ref_discharge_o         <= `DMMFD_BIT_RST;
            ohm_source_output_o         <= `DMMFD_OSO_HIZ;
            charge_discharge_toggle_o   <= `DMMFD_BIT_RST;
        end else begin
            cap_measure_flag_o          <= cap_d;
            diode_test_flag_o           <= diode_d;
            source_voltage_enable_o     <= src_en_d;
            short_test_flag_o           <= short_d;
            direct_voltage_out_enable_o <= dir_out_d;
            sw_1k_ctrl_o                <= s1k_w;
            sw_10k_ctrl_o               <= s10k_w;
            sw_100k_ctrl_o              <= s100k_w;
            sw_1meg_ctrl_o              <= s1m_w;
            sw_10meg_ctrl_o             <= s10m_d;
            ref_gen_enable_o            <= src_en_d;
            ref_sel_zener_o             <= src_en_d & ~div_sel_q;
            ref_sel_supply_o            <= src_en_d & div_sel_q;
            cmp_ref_set1_o              <= src_en_d & ~cap_lvl_q;
            cmp_ref_set2_o              <= src_en_d & cap_lvl_q;
            cmp_ref_discharge_o         <= cap_d & tog_w;
            ohm_source_output_o         <= oso_d;
            charge_discharge_toggle_o   <= tog_w;
        end
    end

    // Read port, data one cycle after strobe and zero otherwise
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `DMMFD_RDATA_RST;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DMMFD_ADDR_FUNC:   reg_rdata_o <= {4'h0, func_q};
                `DMMFD_ADDR_RANGE:  reg_rdata_o <= {4'h0, range_q};
                `DMMFD_ADDR_CTRL:   reg_rdata_o <= {4'h0, cap_lvl_q, div_sel_q, oss_q};
                // Status is read-only and shows the live decode
                `DMMFD_ADDR_STATUS: reg_rdata_o <= {2'h0, tog_w, cap_d, diode_d,
                                                    src_en_d, short_d, dir_out_d};
                default:            reg_rdata_o <= `DMMFD_RDATA_RST;
            endcase
        end else begin
            reg_rdata_o <= `DMMFD_RDATA_RST;
        end
    end

endmodule

// One resistor path switch lane: 0aa in divider mode, aaa in R and C modes
module dmmfd_sw_lane #(
    parameter WIDTH = 3
) (
    // Mode group and range bit
    input  wire             div_mode_i,
    input  wire             rc_mode_i,
    input  wire             range_bit_i,
    // Switch code
    output reg  [WIDTH-1:0] code_o
);

    // Other modes leave every switch of the lane open
    always @* begin
        code_o = {WIDTH{1'h0}};
        if (div_mode_i) begin
            code_o = {1'h0, {(WIDTH-1){range_bit_i}}};
        end else if (rc_mode_i) begin
            code_o = {WIDTH{range_bit_i}};
        end
    end

endmodule

// [bench/dmmfd_props.sv]
// Port-level assertions for the multimeter function decoder
`timescale 1ns/10ps
`include "dmmfd_consts.vh"
module dmmfd_props (
    // Clock and reset
    input logic       sys_clk_i,
    input logic       rst_i,
    // Register port and comparator pin
    input logic       reg_rd_i,
    input logic [7:0] reg_rdata_o,
    input logic       comparator_one_i,
    // Decoded flags
    input logic       cap_measure_flag_o,
    input logic       diode_test_flag_o,
    input logic       source_voltage_enable_o,
    input logic       short_test_flag_o,
    input logic       direct_voltage_out_enable_o,
    // Switch codes
    input logic [2:0] sw_1k_ctrl_o,
    input logic [2:0] sw_10k_ctrl_o,
    input logic [2:0] sw_100k_ctrl_o,
    input logic [2:0] sw_1meg_ctrl_o,
    input logic [1:0] sw_10meg_ctrl_o,
    // Reference and ohm path
    input logic       ref_gen_enable_o,
    input logic       ref_sel_zener_o,
    input logic       ref_sel_supply_o,
    input logic       cmp_ref_set1_o,
    input logic       cmp_ref_set2_o,
    input logic [2:0] ohm_source_output_o,
    input logic       charge_discharge_toggle_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // f bit recovered from the low bits of the tripled codes
    wire f_bit = ~(sw_1k_ctrl_o[0] | sw_10k_ctrl_o[0] | sw_100k_ctrl_o[0] | sw_1meg_ctrl_o[0]);
    wire rc_mode = cap_measure_flag_o | short_test_flag_o;
    // Three quiet cycles after reset
    sequence out_of_reset;
        !rst_i [*3];
    endsequence
    src_decode_a: assert property (source_voltage_enable_o == (rc_mode | direct_voltage_out_enable_o))
        else $error("source enable disagrees with mode flags");
    diode_alone_a: assert property (diode_test_flag_o |-> !source_voltage_enable_o && !rc_mode)
        else $error("diode flag with other flags");
    ref_gate_a: assert property (ref_gen_enable_o == source_voltage_enable_o)
        else $error("reference generator gate wrong");
    ref_pick_a: assert property ((ref_sel_zener_o | ref_sel_supply_o) == ref_gen_enable_o
        && !(ref_sel_zener_o && ref_sel_supply_o)) else $error("reference source select wrong");
    cmp_set_a: assert property ((cmp_ref_set1_o ^ cmp_ref_set2_o) == source_voltage_enable_o)
        else $error("comparator reference set wrong");
    cap_ohm_a: assert property (cap_measure_flag_o |-> ohm_source_output_o ==
        (charge_discharge_toggle_o ? `DMMFD_OSO_GND : `DMMFD_OSO_REFLVL)) else $error("cap path wrong");
    f_code_a: assert property (rc_mode |-> sw_10meg_ctrl_o[1] == f_bit)
        else $error("10M code high bit wrong");
    code_triple_a: assert property (rc_mode |-> sw_1k_ctrl_o inside {3'h0, 3'h7}
        && sw_1meg_ctrl_o inside {3'h0, 3'h7}) else $error("switch code not tripled");
    toggle_lag_a: assert property (out_of_reset ##1 1'h1 |->
        charge_discharge_toggle_o == $past(comparator_one_i, 3)) else $error("toggle lag wrong");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind dmmfd_top dmmfd_props u_dmmfd_props (.sys_clk_i, .rst_i, .reg_rd_i, .reg_rdata_o,
    .comparator_one_i, .cap_measure_flag_o, .diode_test_flag_o, .source_voltage_enable_o,
    .short_test_flag_o, .direct_voltage_out_enable_o, .sw_1k_ctrl_o, .sw_10k_ctrl_o,
    .sw_100k_ctrl_o, .sw_1meg_ctrl_o, .sw_10meg_ctrl_o, .ref_gen_enable_o, .ref_sel_zener_o,
    .ref_sel_supply_o, .cmp_ref_set1_o, .cmp_ref_set2_o, .ohm_source_output_o,
    .charge_discharge_toggle_o);

// [bench/tb_dmmfd_top.sv]
// Self-checking bench for the multimeter function decoder
`timescale 1ns/10ps
`include "dmmfd_consts.vh"
module tb_dmmfd_top;
    logic       sys_clk_i, rst_i, reg_wr_i, reg_rd_i, comparator_one_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic       cap_measure_flag_o, diode_test_flag_o, source_voltage_enable_o;
    logic       short_test_flag_o, direct_voltage_out_enable_o, ref_gen_enable_o;
    logic       ref_sel_zener_o, ref_sel_supply_o, cmp_ref_set1_o, cmp_ref_set2_o;
    logic       cmp_ref_discharge_o, charge_discharge_toggle_o;
    logic [2:0] sw_1k_ctrl_o, sw_10k_ctrl_o, sw_100k_ctrl_o, sw_1meg_ctrl_o, ohm_source_output_o;
    logic [1:0] sw_10meg_ctrl_o;
    int         n_errors, checks, m, r;

    dmmfd_top u_dmmfd_top (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .comparator_one_i, .cap_measure_flag_o, .diode_test_flag_o,
        .source_voltage_enable_o, .short_test_flag_o, .direct_voltage_out_enable_o,
        .sw_1k_ctrl_o, .sw_10k_ctrl_o, .sw_100k_ctrl_o, .sw_1meg_ctrl_o, .sw_10meg_ctrl_o,
        .ref_gen_enable_o, .ref_sel_zener_o, .ref_sel_supply_o, .cmp_ref_set1_o,
        .cmp_ref_set2_o, .cmp_ref_discharge_o, .ohm_source_output_o, .charge_discharge_toggle_o);

    // 250 MHz clock
    initial begin
        sys_clk_i = 1'h0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'h0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'h0;
        #1 chk(what, reg_rdata_o, exp);
    endtask
    // Register then output flop
    task automatic settle;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    // Expected flags {cap,diode,src,short,direct} and switch codes
    function automatic logic [18:0] expv(input logic [3:0] f, input logic [3:0] g);
        logic [4:0]  fl;
        logic [13:0] sw;
        logic        e;
        e  = |g;
        fl = 5'h00;
        sw = 14'h0000;
        if (f == 4'h1) fl = 5'h08;
        if (f == 4'h3) fl = 5'h05;
        if (f[3:1] == 3'h4) fl = 5'h06;
        if (f[3:1] == 3'h5) fl = 5'h14;
        if (f[3:2] == 2'h0) sw = {1'h0, {2{g[3]}}, 1'h0, {2{g[2]}}, 1'h0, {2{g[1]}}, 1'h0,
            {2{g[0]}}, 1'h0, e};
        if (f[3:2] == 2'h2) sw = {{3{g[3]}}, {3{g[2]}}, {3{g[1]}}, {3{g[0]}}, ~e, f[0] ? ~e : 1'h1};
        return {fl, sw};
    endfunction
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, comparator_one_i} = 4'h8;
        reg_addr_i  = 4'h0;
        reg_wdata_i = 8'h00;
        n_errors    = 0;
        checks      = 0;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        #1 chk("ohm path at reset", ohm_source_output_o, `DMMFD_OSO_HIZ);
        rd(`DMMFD_ADDR_CTRL, 8'h00, "ctrl at reset");
        rd(4'h9, 8'h00, "unmapped read");
        // Every function code against three range patterns
        for (r = 0; r < 3; r++) begin
            wr(`DMMFD_ADDR_RANGE, 8'(r * 5));
            for (m = 0; m < 16; m++) begin
                wr(`DMMFD_ADDR_FUNC, 8'(m));
                settle();
                chk("decode", {cap_measure_flag_o, diode_test_flag_o, source_voltage_enable_o,
                    short_test_flag_o, direct_voltage_out_enable_o, sw_1k_ctrl_o, sw_10k_ctrl_o,
                    sw_100k_ctrl_o, sw_1meg_ctrl_o, sw_10meg_ctrl_o}, expv(4'(m), 4'(r * 5)));
            end
        end
        rd(`DMMFD_ADDR_RANGE, 8'h0A, "range readback");
        rd(`DMMFD_ADDR_FUNC, 8'h0F, "func readback");
        // Control field sweep in resistor mode
        wr(`DMMFD_ADDR_FUNC, 8'h08);
        for (r = 0; r < 16; r++) begin
            wr(`DMMFD_ADDR_CTRL, 8'(r));
            settle();
            chk("ohm path", ohm_source_output_o, r % 4);
            chk("ref select", {ref_gen_enable_o, ref_sel_zener_o, ref_sel_supply_o, cmp_ref_set1_o,
                cmp_ref_set2_o}, {1'h1, !r[2], r[2], !r[3], r[3]});
        end
        rd(`DMMFD_ADDR_CTRL, 8'h0F, "ctrl readback");
        wr(`DMMFD_ADDR_FUNC, 8'h00);
        settle();
        chk("ref off", {ref_gen_enable_o, ref_sel_zener_o, ref_sel_supply_o}, 0);
        chk("ohm supply", ohm_source_output_o, `DMMFD_OSO_SUPPLY);
        // Capacitor mode with the comparator flipping
        wr(`DMMFD_ADDR_FUNC, 8'h0A);
        for (r = 0; r < 4; r++) begin
            @(posedge sys_clk_i);
            comparator_one_i <= r[0];
            repeat (4) @(posedge sys_clk_i);
            #1 chk("toggle", charge_discharge_toggle_o, r[0]);
            chk("cap path", ohm_source_output_o, r[0] ? `DMMFD_OSO_GND : `DMMFD_OSO_REFLVL);
            chk("discharge", cmp_ref_discharge_o, r[0]);
            rd(`DMMFD_ADDR_STATUS, {2'h0, r[0], 5'h14}, "status");
        end
        // Reset in mid-run
        @(posedge sys_clk_i);
        rst_i <= 1'h1;
        @(posedge sys_clk_i);
        rst_i <= 1'h0;
        #1 chk("after reset", {cap_measure_flag_o, source_voltage_enable_o,
            charge_discharge_toggle_o, ohm_source_output_o}, 0);
        rd(`DMMFD_ADDR_FUNC, 8'h00, "func after reset");
        wrap_up();
    end
endmodule
